// file: bench/cpuide_core_assertions.sv
`timescale 1ns/10ps
`include "cpuide_map.vh"
module cpuide_core_checker (
	input wire        i_ref_clk,
	input wire        i_rst_n,
	input wire [7:0]  i_din,
	input wire [15:0] o_addr,
	input wire [7:0]  o_dout,
	input wire        o_rd,
	input wire        o_wr,
	input wire        o_io,
	input wire        o_fetch
);
	logic        pfx;
	logic        ed;
	wire         fch = o_rd && o_fetch;
	wire         op  = fch && !pfx;
	wire         eop = fch && ed;
	wire  [15:0] dsx = {{8{i_din[7]}}, i_din};

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	// ------------------------------------------------------------
	// Prefix tracking
	// ------------------------------------------------------------
	// Only the real opcode byte may start a timing check
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pfx <= 1'b0;
			ed  <= 1'b0;
		end else if (fch) begin
			pfx <= i_din == `CPUIDE_PFX_IX || i_din == `CPUIDE_PFX_IY || i_din == `CPUIDE_PFX_ED;
			ed  <= i_din == `CPUIDE_PFX_ED;
		end
	end

	sequence s_fetch;
		o_rd && o_fetch;
	endsequence
	sequence s_pair_write;
		o_wr && !o_rd ##1 o_wr && o_addr == $past(o_addr) - 16'h0001;
	endsequence
	sequence s_nn_write;
		o_wr && o_addr == {$past(i_din, 2), $past(i_din, 4)} ##1 o_wr && o_addr == $past(o_addr) + 16'h0001;
	endsequence

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_JP_TIME: assert property (op && (i_din == `CPUIDE_OP_JP || (i_din[7:6] == 2'b11 &&
		i_din[2:0] == 3'b010)) |-> ##10 s_fetch) else $error("absolute jump length wrong");
	AST_JR_TARGET: assert property (op && i_din == `CPUIDE_OP_JR |->
		##2 (o_rd && !o_fetch && o_addr == $past(o_addr, 2) + 16'h0001)
		##10 (o_rd && o_fetch && o_addr == $past(o_addr, 12) + 16'h0002 + $past(dsx, 10)))
		else $error("relative branch wrong");
	AST_JRCC_TIME: assert property (op && i_din[7:5] == 3'b001 && i_din[2:0] == 3'b000 |->
		(##7 s_fetch) or (##12 s_fetch)) else $error("conditional branch length wrong");
	AST_ROTATE: assert property (op && i_din[7:5] == 3'b000 && i_din[2:0] == 3'b111 |->
		##1 (!o_rd && !o_wr) [*3] ##1 (o_rd && o_fetch && o_addr == $past(o_addr, 4) + 16'h0001))
		else $error("rotate length wrong");
	AST_ADD16: assert property (op && i_din[7:6] == 2'b00 && i_din[3:0] == 4'h9 |-> ##11 s_fetch)
		else $error("pair add length wrong");
	AST_PUSH: assert property (op && i_din[7:6] == 2'b11 && i_din[3:0] == 4'h5 |->
		##2 s_pair_write ##8 s_fetch) else $error("stack store wrong");
	AST_ED_STORE: assert property (eop && i_din[7:6] == 2'b01 && i_din[3:0] == 4'h3 |->
		##6 s_nn_write ##11 s_fetch) else $error("extended store wrong");
	AST_IN_PORT: assert property (eop && i_din[7:6] == 2'b01 && i_din[2:0] == 3'b000 |->
		##2 (o_rd && o_io && !o_fetch) ##8 s_fetch) else $error("port input wrong");
	AST_SEARCH: assert property (eop && i_din[7:5] == 3'b101 && i_din[2:0] == 3'b001 |->
		(##14 s_fetch) or (##19 s_fetch)) else $error("block compare length wrong");
	AST_IO_QUAL: assert property (o_io |-> o_rd && !o_fetch && !o_wr)
		else $error("port strobe misqualified");
endmodule

bind cpuide_core cpuide_core_checker cpuide_core_checker_inst (
	.i_ref_clk (i_ref_clk),
	.i_rst_n   (i_rst_n),
	.i_din     (i_din),
	.o_addr    (o_addr),
	.o_dout    (o_dout),
	.o_rd      (o_rd),
	.o_wr      (o_wr),
	.o_io      (o_io),
	.o_fetch   (o_fetch)
);

// file: bench/cpuide_mem_model.sv
`timescale 1ns/10ps
module cpuide_mem_model #(
	parameter [7:0] PORT_DATA = 8'h81
) (
	// Core bus
	input  wire        i_ref_clk,
	input  wire [15:0] i_addr,
	input  wire [7:0]  i_dout,
	input  wire        i_rd,
	input  wire        i_wr,
	input  wire        i_io,
	// Read answer
	output logic [7:0] o_din
);
	logic [7:0] mem [0:65535];
	logic [7:0] idle_pat = 8'hA5;

	// ------------------------------------------------------------
	// Zero-wait answer
	// ------------------------------------------------------------
	// Idle bus toggles every cycle so stale data never looks valid
	always_comb begin
		if (i_rd && i_io)
			o_din = PORT_DATA;
		else if (i_rd)
			o_din = mem[i_addr];
		else
			o_din = idle_pat;
	end

	always @(posedge i_ref_clk) begin
		idle_pat <= ~idle_pat;
		if (i_wr)
			mem[i_addr] <= i_dout;
	end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        i_ref_clk;
	logic        i_rst_n;
	logic [7:0]  i_din;
	logic [15:0] o_addr;
	logic [7:0]  o_dout;
	logic        o_rd;
	logic        o_wr;
	logic        o_io;
	logic        o_fetch;
	int          fails;
	int          compares;
	int          cyc = 0;
	int          t_at [0:255];
	logic [15:0] io_seen;
	logic [15:0] hit;
	logic [7:0]  prog [$];

	cpuide_core cpuide_core_inst (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_din     (i_din),
		.o_addr    (o_addr),
		.o_dout    (o_dout),
		.o_rd      (o_rd),
		.o_wr      (o_wr),
		.o_io      (o_io),
		.o_fetch   (o_fetch)
	);
	cpuide_mem_model cpuide_mem_model_inst (
		.i_ref_clk (i_ref_clk),
		.i_addr    (o_addr),
		.i_dout    (o_dout),
		.i_rd      (o_rd),
		.i_wr      (o_wr),
		.i_io      (o_io),
		.o_din     (i_din)
	);

	initial begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	// Fetch times of low addresses give instruction lengths
	always @(posedge i_ref_clk) begin
		cyc <= cyc + 1;
		if (o_rd && o_fetch && o_addr < 16'h0100)
			t_at[o_addr[7:0]] <= cyc;
		if (o_rd && o_io)
			io_seen <= o_addr;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [7:0] rd_m(input logic [15:0] a);
		return cpuide_mem_model_inst.mem[a];
	endfunction

	task automatic start;
		int i;
		@(posedge i_ref_clk);
		i_rst_n <= 1'b0;
		for (i = 0; i < 65536; i++)
			cpuide_mem_model_inst.mem[i] = 8'h00;
	endtask

	task automatic put(input logic [15:0] base);
		int i;
		for (i = 0; i < prog.size(); i++)
			cpuide_mem_model_inst.mem[base + i] = prog[i];
	endtask

	// Release reset, wait for a fetch at either stop address
	task automatic go(input logic [15:0] sa, input logic [15:0] sb);
		int k;
		repeat (20) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		hit = 16'hFFFF;
		for (k = 0; k < 3000 && hit === 16'hFFFF; k++) begin
			@(posedge i_ref_clk);
			#1;
			if (o_rd === 1'b1 && o_fetch === 1'b1 && (o_addr === sa || o_addr === sb))
				hit = o_addr;
		end
		if (hit === 16'hFFFF) begin
			fails++;
			conclude();
		end
		@(posedge i_ref_clk);
		#1;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_alu;
		logic [7:0] res [0:7];
		logic [7:0] flg [0:7];
		int op;
		res = '{8'h1D, 8'h1D, 8'h97, 8'h97, 8'h42, 8'h99, 8'hDB, 8'h5A};
		flg = '{8'h01, 8'h01, 8'h87, 8'h87, 8'h14, 8'h84, 8'h84, 8'h87};
		for (op = 0; op < 8; op++) begin
			start();
			prog = '{8'h3E, 8'h5A, 8'h06, 8'hC3, {2'b10, op[2:0], 3'b000}, 8'hF5, 8'h18, 8'hFE};
			put(16'h0000);
			go(16'h0006, 16'h0006);
			chk(rd_m(16'hFFFE), res[op]);
			chk(rd_m(16'hFFFD) & 8'hD7, flg[op]);
		end
		$display("alu test done");
	endtask

	task automatic test_rot;
		logic [7:0] opc [0:3];
		logic [7:0] res [0:3];
		int i;
		opc = '{8'h07, 8'h17, 8'h0F, 8'h1F};
		res = '{8'h03, 8'h02, 8'hC0, 8'h40};
		for (i = 0; i < 4; i++) begin
			start();
			// AND first leaves half-carry set, which must be cleared
			prog = '{8'h3E, 8'h00, 8'hA7, 8'h3E, 8'h81, opc[i], 8'hF5, 8'h18, 8'hFE};
			put(16'h0000);
			go(16'h0007, 16'h0007);
			chk(rd_m(16'hFFFE), res[i]);
			chk(rd_m(16'hFFFD) & 8'hD7, 8'h45);
			chk(t_at[6] - t_at[5], 4);
		end
		$display("rotate test done");
	endtask

	task automatic test_jpcc;
		logic [7:0] taken;
		int s;
		int cc;
		for (s = 0; s < 2; s++) begin
			taken = s ? 8'hA5 : 8'h5A;
			for (cc = 0; cc < 8; cc++) begin
				start();
				prog = '{8'h3E, s ? 8'h40 : 8'hFF, 8'h06, s ? 8'h40 : 8'h01, 8'h80,
					{2'b11, cc[2:0], 3'b010}, 8'h40, 8'h00, 8'h18, 8'hFE};
				put(16'h0000);
				prog = '{8'h18, 8'hFE};
				put(16'h0040);
				go(16'h0008, 16'h0040);
				chk(hit, taken[cc] ? 16'h0040 : 16'h0008);
			end
		end
		$display("jump test done");
	endtask

	task automatic test_jr;
		logic [7:0]  dsp [0:1];
		logic [15:0] tgt [0:1];
		int i;
		dsp = '{8'h7F, 8'h80};
		tgt = '{16'h0181, 16'h0082};
		for (i = 0; i < 4; i++) begin
			start();
			if (i < 2) begin
				prog = '{8'hC3, 8'h00, 8'h01};
				put(16'h0000);
				prog = '{8'h18, dsp[i]};
				put(16'h0100);
				prog = '{8'h18, 8'hFE};
				put(tgt[i]);
				go(tgt[i], 16'h0102);
				chk(hit, tgt[i]);
			end else begin
				// Carry set: no-carry form falls through, carry form branches
				prog = '{8'h3E, 8'hFF, 8'h06, 8'h01, 8'h80, i[0] ? 8'h38 : 8'h30, 8'h10, 8'h18, 8'hFE};
				put(16'h0000);
				prog = '{8'h18, 8'hFE};
				put(16'h0017);
				go(16'h0007, 16'h0017);
				chk(hit, i[0] ? 16'h0017 : 16'h0007);
				chk(t_at[hit[7:0]] - t_at[5], i[0] ? 12 : 7);
			end
		end
		$display("branch test done");
	endtask

	task automatic test_stack;
		logic [7:0] ev [0:11];
		int i;
		ev = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hF9, 8'hFF, 8'h78, 8'h56, 8'hF0, 8'hAC};
		start();
		prog = '{8'h06, 8'h12, 8'h0E, 8'h34, 8'h16, 8'h56, 8'h1E, 8'h78, 8'h26, 8'h9A, 8'h2E, 8'hBC,
			8'hC5, 8'hD5, 8'hE5, 8'hED, 8'h73, 8'h80, 8'h00, 8'hED, 8'h53, 8'h82, 8'h00,
			8'h09, 8'h22, 8'h84, 8'h00, 8'h18, 8'hFE};
		put(16'h0000);
		go(16'h001B, 16'h001B);
		for (i = 0; i < 12; i++)
			chk(rd_m(i < 6 ? 16'hFFFE - i : 16'h007A + i), ev[i]);
		$display("stack test done");
	endtask

	task automatic test_search;
		logic [7:0] ev [0:7];
		logic [15:0] ad [0:7];
		int i;
		ev = '{8'h33, 8'h46, 8'h77, 8'h02, 8'h03, 8'h02, 8'h00, 8'h00};
		ad = '{16'hFFFE, 16'hFFFD, 16'hFFFC, 16'hFFFB, 16'h0080, 16'h0081, 16'h0082, 16'h0083};
		start();
		prog = '{8'h06, 8'h00, 8'h0E, 8'h03, 8'h26, 8'h02, 8'h2E, 8'h00, 8'h3E, 8'h33, 8'hED, 8'hB1,
			8'hF5, 8'h3E, 8'h77, 8'hED, 8'hB1, 8'hF5, 8'h22, 8'h80, 8'h00, 8'hED, 8'h43, 8'h82,
			8'h00, 8'h18, 8'hFE};
		put(16'h0000);
		prog = '{8'h11, 8'h33, 8'h44};
		put(16'h0200);
		go(16'h0019, 16'h0019);
		for (i = 0; i < 8; i++)
			chk(rd_m(ad[i]) & (i[0] && i < 4 ? 8'hD7 : 8'hFF), ev[i]);
		chk(t_at[12] - t_at[10], 16);
		chk(t_at[17] - t_at[15], 16);
		$display("search test done");
	endtask

	task automatic test_port;
		start();
		prog = '{8'h06, 8'h12, 8'h0E, 8'h34, 8'hED, 8'h78, 8'hF5, 8'h06, 8'h03, 8'h0E, 8'h00,
			8'hDD, 8'h09, 8'hDD, 8'h77, 8'hFF, 8'hFD, 8'h77, 8'h7F, 8'h18, 8'hFE};
		put(16'h0000);
		go(16'h0013, 16'h0013);
		chk(io_seen, 16'h1234);
		chk(t_at[6] - t_at[4], 12);
		chk(rd_m(16'hFFFE), 8'h81);
		chk(rd_m(16'hFFFD) & 8'hD7, 8'h84);
		chk(rd_m(16'h02FF), 8'h81);
		chk(rd_m(16'h007F), 8'h81);
		$display("port and index test done");
	endtask

	initial begin
		i_rst_n = 1'b0;
		fails = 0;
		compares = 0;
		test_alu();
		test_rot();
		test_jpcc();
		test_jr();
		test_stack();
		test_search();
		test_port();
		conclude();
	end
endmodule

// file: inc/cpuide_map.vh
`ifndef CPUIDE_MAP_VH
`define CPUIDE_MAP_VH

// ------------------------------------------------------------
// Opcodes and prefixes
// ------------------------------------------------------------
`define CPUIDE_PFX_IX     8'hDD
`define CPUIDE_PFX_IY     8'hFD
`define CPUIDE_PFX_ED     8'hED
`define CPUIDE_OP_JR      8'h18
`define CPUIDE_OP_JP      8'hC3
`define CPUIDE_OP_ST16    8'h22
`define CPUIDE_OP_INA     8'hDB
`define CPUIDE_OP_JPHL    8'hE9
`define CPUIDE_OP_LDSP    8'hF9
`define CPUIDE_OP_HALT    8'h76

// ------------------------------------------------------------
// Flag bit positions
// ------------------------------------------------------------
`define CPUIDE_F_S        7
`define CPUIDE_F_Z        6
`define CPUIDE_F_H        4
`define CPUIDE_F_PV       2
`define CPUIDE_F_N        1
`define CPUIDE_F_C        0

// ------------------------------------------------------------
// T-states per instruction, one clock each
// ------------------------------------------------------------
`define CPUIDE_T_REG      5'h04
`define CPUIDE_T_MEM      5'h07
`define CPUIDE_T_IDX      5'h13
`define CPUIDE_T_LDN_MEM  5'h0A
`define CPUIDE_T_ADD16    5'h0B
`define CPUIDE_T_ST16     5'h10
`define CPUIDE_T_JR       5'h0C
`define CPUIDE_T_JR_NOT   5'h07
`define CPUIDE_T_JP       5'h0A
`define CPUIDE_T_PUSH     5'h0B
`define CPUIDE_T_POP      5'h0A
`define CPUIDE_T_INA      5'h0B
`define CPUIDE_T_LDSP     5'h06
`define CPUIDE_T_ED_ST    5'h14
`define CPUIDE_T_ED_IN    5'h0C
`define CPUIDE_T_CPS      5'h10
`define CPUIDE_T_CPS_RPT  5'h15
`define CPUIDE_T_ED_NOP   5'h08
`define CPUIDE_T_PFX_ADD  5'h04

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CPUIDE_RST_PC     16'h0000
`define CPUIDE_RST_SP     16'hFFFF
`define CPUIDE_RST_REG    8'h00

`endif

// file: rtl/cpuide_alu.v
`timescale 1ns/10ps
module cpuide_alu (
	// Operation
	input  wire [2:0] i_op,
	input  wire [7:0] i_a,
	input  wire [7:0] i_b,
	input  wire       i_cin,
	// Result, flags as {S,Z,H,PV,N,C}
	output reg  [7:0] o_res,
	output reg  [5:0] o_flags
);
	reg [8:0] sum;
	reg [4:0] nib;
	reg       cy;
	reg       hc;
	reg       pv;
	reg       sub;

	always @* begin
		sum = 9'h000;
		nib = 5'h00;
		cy  = (i_op == 3'h1 || i_op == 3'h3) ? i_cin : 1'b0;
		sub = (i_op == 3'h2 || i_op == 3'h3 || i_op == 3'h7);
		hc  = 1'b0;
		pv  = 1'b0;
		o_res = 8'h00;
		case (i_op)
		3'h0, 3'h1: begin
			sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cy};
			nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cy};
			o_res = sum[7:0];
			hc = nib[4];
			pv = (i_a[7] == i_b[7]) && (sum[7] != i_a[7]);
		end
		3'h2, 3'h3, 3'h7: begin
			sum = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cy};
			nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cy};
			o_res = sum[7:0];
			hc = nib[4];
			pv = (i_a[7] != i_b[7]) && (sum[7] != i_a[7]);
		end
		3'h4: begin
			o_res = i_a & i_b;
			hc = 1'b1;
		end
		3'h5: o_res = i_a ^ i_b;
		default: o_res = i_a | i_b;
		endcase
		// Logical ops: carry cleared, parity in PV
		if (i_op[2] && i_op != 3'h7) begin
			pv = ~^o_res;
		end
		o_flags = {o_res[7], (o_res == 8'h00), hc, pv, sub, (i_op[2] && i_op != 3'h7) ? 1'b0 : sum[8]};
	end
endmodule

// file: rtl/cpuide_core.v
`timescale 1ns/10ps
`include "cpuide_map.vh"
module cpuide_core (
	// Clock and reset
	input  wire        i_ref_clk,
	input  wire        i_rst_n,
	// Processor bus
	input  wire [7:0]  i_din,
	output reg  [15:0] o_addr,
	output reg  [7:0]  o_dout,
	output reg         o_rd,
	output reg         o_wr,
	output reg         o_io,
	output reg         o_fetch
);
	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] S_FETCH = 4'h0;
	localparam [3:0] S_DEC   = 4'h1;
	localparam [3:0] S_RDI   = 4'h2;
	localparam [3:0] S_CAPI  = 4'h3;
	localparam [3:0] S_RDM   = 4'h4;
	localparam [3:0] S_CAPM  = 4'h5;
	localparam [3:0] S_EXEC  = 4'h6;
	localparam [3:0] S_WR2   = 4'h7;
	localparam [3:0] S_PAD   = 4'h8;

	reg [3:0]  state;
	reg [7:0]  opc;
	reg        ed;
	reg [1:0]  idx;
	reg        pfx_cont;
	reg [7:0]  disp;
	reg [15:0] imm;
	reg [15:0] mdat;
	reg [1:0]  ileft;
	reg        dpend;
	reg [1:0]  mleft;
	reg        moff;
	reg [4:0]  target;
	reg [4:0]  tcnt;
	reg [15:0] wa1;
	reg [7:0]  wd1;
	reg [15:0] pc;
	reg [15:0] sp;
	reg [15:0] ix;
	reg [15:0] iy;
	reg [7:0]  rf [0:7];
	integer    k;

	// ------------------------------------------------------------
	// Register views; flags live in slot 6
	// ------------------------------------------------------------
	wire [7:0]  fl    = rf[6];
	wire [7:0]  acc   = rf[7];
	wire [15:0] bc    = {rf[0], rf[1]};
	wire [15:0] hl    = {rf[4], rf[5]};
	wire [15:0] hlx   = (idx == 2'h1) ? ix : (idx == 2'h2) ? iy : hl;
	wire [15:0] dsx   = {{8{disp[7]}}, disp};
	wire [7:0]  byte8 = mdat[15:8];
	wire [7:0]  n8    = imm[15:8];
	wire [7:0]  cur_op = (state == S_DEC) ? i_din : opc;

	function cond_ok;
		input [2:0] cc;
		begin
			case (cc)
			3'h0:    cond_ok = ~fl[`CPUIDE_F_Z];
			3'h1:    cond_ok = fl[`CPUIDE_F_Z];
			3'h2:    cond_ok = ~fl[`CPUIDE_F_C];
			3'h3:    cond_ok = fl[`CPUIDE_F_C];
			3'h4:    cond_ok = ~fl[`CPUIDE_F_PV];
			3'h5:    cond_ok = fl[`CPUIDE_F_PV];
			3'h6:    cond_ok = ~fl[`CPUIDE_F_S];
			default: cond_ok = fl[`CPUIDE_F_S];
			endcase
		end
	endfunction

	function [15:0] pair_of;
		input [1:0] c;
		input       af;
		begin
			case (c)
			2'h0:    pair_of = bc;
			2'h1:    pair_of = {rf[2], rf[3]};
			2'h2:    pair_of = hlx;
			default: pair_of = af ? {acc, fl} : sp;
			endcase
		end
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire k_ldrr  = !ed && cur_op[7:6] == 2'h1 && cur_op != `CPUIDE_OP_HALT;
	wire k_alu   = !ed && (cur_op[7:6] == 2'h2 || (cur_op[7:6] == 2'h3 && cur_op[2:0] == 3'h6));
	wire k_ldn   = !ed && cur_op[7:6] == 2'h0 && cur_op[2:0] == 3'h6;
	wire k_add16 = !ed && cur_op[7:6] == 2'h0 && cur_op[3:0] == 4'h9;
	wire k_st16  = !ed && cur_op == `CPUIDE_OP_ST16;
	wire k_rot   = !ed && cur_op[7:5] == 3'h0 && cur_op[2:0] == 3'h7;
	wire k_jr    = !ed && (cur_op == `CPUIDE_OP_JR || (cur_op[7:5] == 3'h1 && cur_op[2:0] == 3'h0));
	wire k_jp    = !ed && (cur_op == `CPUIDE_OP_JP || (cur_op[7:6] == 2'h3 && cur_op[2:0] == 3'h2));
	wire k_push  = !ed && cur_op[7:6] == 2'h3 && cur_op[3:0] == 4'h5;
	wire k_pop   = !ed && cur_op[7:6] == 2'h3 && cur_op[3:0] == 4'h1;
	wire k_ina   = !ed && cur_op == `CPUIDE_OP_INA;
	wire k_jphl  = !ed && cur_op == `CPUIDE_OP_JPHL;
	wire k_ldsp  = !ed && cur_op == `CPUIDE_OP_LDSP;
	wire k_edst  = ed && cur_op[7:6] == 2'h1 && cur_op[3:0] == 4'h3;
	wire k_edin  = ed && cur_op[7:6] == 2'h1 && cur_op[2:0] == 3'h0;
	wire k_cps   = ed && cur_op[7:5] == 3'h5 && cur_op[2:0] == 3'h1;
	wire mem_src = (k_ldrr && cur_op[2:0] == 3'h6) || (k_alu && cur_op[7:6] == 2'h2 && cur_op[2:0] == 3'h6);
	wire mem_hl  = mem_src || (k_ldrr && cur_op[5:3] == 3'h6) || (k_ldn && cur_op[5:3] == 3'h6);
	wire need_d  = (idx != 2'h0) && mem_hl;
	wire imm1    = k_ldn || (k_alu && cur_op[7:6] == 2'h3) || k_jr || k_ina;
	wire imm2    = k_jp || k_st16 || k_edst;
	wire [1:0] nimm = imm2 ? 2'h2 : {1'b0, imm1};
	wire [1:0] nmrd = k_pop ? 2'h2 : {1'b0, mem_src || k_ina || k_edin || k_cps};
	wire io      = k_ina || k_edin;
	wire jr_take = (cur_op == `CPUIDE_OP_JR) || cond_ok({1'b0, cur_op[4:3]});
	wire [15:0] ea = k_pop ? sp : k_ina ? {acc, n8} : k_edin ? bc : k_cps ? hl : hlx + dsx;

	reg [4:0] base_t;
	always @* begin
		base_t = ed ? `CPUIDE_T_ED_NOP : `CPUIDE_T_REG;
		if (mem_src || k_ldn)
			base_t = (k_ldn && cur_op[5:3] == 3'h6) ? `CPUIDE_T_LDN_MEM : `CPUIDE_T_MEM;
		else if (k_ldrr && cur_op[5:3] == 3'h6)
			base_t = `CPUIDE_T_MEM;
		else if (k_alu && cur_op[7:6] == 2'h3)
			base_t = `CPUIDE_T_MEM;
		else if (k_add16)
			base_t = `CPUIDE_T_ADD16;
		else if (k_st16)
			base_t = `CPUIDE_T_ST16;
		else if (k_jr)
			base_t = jr_take ? `CPUIDE_T_JR : `CPUIDE_T_JR_NOT;
		else if (k_jp)
			base_t = `CPUIDE_T_JP;
		else if (k_push)
			base_t = `CPUIDE_T_PUSH;
		else if (k_pop)
			base_t = `CPUIDE_T_POP;
		else if (k_ina)
			base_t = `CPUIDE_T_INA;
		else if (k_ldsp)
			base_t = `CPUIDE_T_LDSP;
		else if (k_edst)
			base_t = `CPUIDE_T_ED_ST;
		else if (k_edin)
			base_t = `CPUIDE_T_ED_IN;
		else if (k_cps)
			base_t = `CPUIDE_T_CPS;
	end
	// IX/IY-prefixed forms cost four more, indexed memory forms are fixed
	wire [4:0] dc_t = need_d ? `CPUIDE_T_IDX : (idx != 2'h0) ? base_t + `CPUIDE_T_PFX_ADD : base_t;

	// ------------------------------------------------------------
	// Datapath helpers
	// ------------------------------------------------------------
	wire [7:0]  src8  = (opc[2:0] == 3'h6) ? byte8 : rf[opc[2:0]];
	wire [7:0]  alu_b = k_cps ? byte8 : (opc[7:6] == 2'h3) ? n8 : src8;
	wire [2:0]  alu_op = k_cps ? 3'h7 : opc[5:3];
	wire [7:0]  alu_res;
	wire [5:0]  alu_f;
	wire [15:0] pp    = pair_of(opc[5:4], 1'b0);
	wire [16:0] s17   = {1'b0, hlx} + {1'b0, pp};
	wire [12:0] s13   = {1'b0, hlx[11:0]} + {1'b0, pp[11:0]};
	wire [15:0] qq    = pair_of(opc[5:4], 1'b1);
	wire [15:0] bcm   = bc - 16'h0001;
	wire [7:0]  rot_res = opc[3] ? {(opc[4] ? fl[`CPUIDE_F_C] : acc[0]), acc[7:1]}
	                             : {acc[6:0], (opc[4] ? fl[`CPUIDE_F_C] : acc[7])};
	wire        rot_c = opc[3] ? acc[0] : acc[7];

	cpuide_alu u_alu (
		.i_op    (alu_op),
		.i_a     (acc),
		.i_b     (alu_b),
		.i_cin   (fl[`CPUIDE_F_C]),
		.o_res   (alu_res),
		.o_flags (alu_f)
	);

	task put_pair;
		input [1:0]  c;
		input        af;
		input [15:0] v;
		begin
			case (c)
			2'h0: begin
				rf[0] <= v[15:8];
				rf[1] <= v[7:0];
			end
			2'h1: begin
				rf[2] <= v[15:8];
				rf[3] <= v[7:0];
			end
			2'h2: begin
				if (idx == 2'h1)
					ix <= v;
				else if (idx == 2'h2)
					iy <= v;
				else begin
					rf[4] <= v[15:8];
					rf[5] <= v[7:0];
				end
			end
			default: begin
				if (af) begin
					rf[7] <= v[15:8];
					rf[6] <= v[7:0];
				end else
					sp <= v;
			end
			endcase
		end
	endtask

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= S_FETCH;
			opc <= 8'h00;
			ed <= 1'b0;
			idx <= 2'h0;
			pfx_cont <= 1'b0;
			disp <= 8'h00;
			imm <= 16'h0000;
			mdat <= 16'h0000;
			ileft <= 2'h0;
			dpend <= 1'b0;
			mleft <= 2'h0;
			moff <= 1'b0;
			target <= `CPUIDE_T_REG;
			tcnt <= 5'h00;
			wa1 <= 16'h0000;
			wd1 <= 8'h00;
			pc <= `CPUIDE_RST_PC;
			sp <= `CPUIDE_RST_SP;
			ix <= 16'h0000;
			iy <= 16'h0000;
			for (k = 0; k < 8; k = k + 1)
				rf[k] <= `CPUIDE_RST_REG;
			o_addr <= 16'h0000;
			o_dout <= 8'h00;
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_io <= 1'b0;
			o_fetch <= 1'b0;
		end else begin
			o_rd <= 1'b0;
			o_wr <= 1'b0;
			o_io <= 1'b0;
			o_fetch <= 1'b0;
			tcnt <= tcnt + 5'h01;
			case (state)
			S_FETCH: begin
				if (pfx_cont)
					pfx_cont <= 1'b0;
				else begin
					tcnt <= 5'h01;
					idx <= 2'h0;
					ed <= 1'b0;
					disp <= 8'h00;
				end
				o_fetch <= 1'b1;
				o_rd <= 1'b1;
				o_addr <= pc;
				pc <= pc + 16'h0001;
				state <= S_DEC;
			end
			S_DEC: begin
				if (!ed && (i_din == `CPUIDE_PFX_IX || i_din == `CPUIDE_PFX_IY)) begin
					idx <= (i_din == `CPUIDE_PFX_IY) ? 2'h2 : 2'h1;
					pfx_cont <= 1'b1;
					state <= S_FETCH;
				end else if (!ed && i_din == `CPUIDE_PFX_ED) begin
					ed <= 1'b1;
					pfx_cont <= 1'b1;
					state <= S_FETCH;
				end else begin
					opc <= i_din;
					dpend <= need_d;
					ileft <= nimm + {1'b0, need_d};
					mleft <= nmrd;
					moff <= 1'b0;
					target <= dc_t;
					if (need_d || nimm != 2'h0)
						state <= S_RDI;
					else if (nmrd != 2'h0)
						state <= S_RDM;
					else
						state <= S_EXEC;
				end
			end
			S_RDI: begin
				o_rd <= 1'b1;
				o_addr <= pc;
				pc <= pc + 16'h0001;
				state <= S_CAPI;
			end
			S_CAPI: begin
				if (dpend) begin
					disp <= i_din;
					dpend <= 1'b0;
				end else
					imm <= {i_din, imm[15:8]};
				ileft <= ileft - 2'h1;
				if (ileft != 2'h1)
					state <= S_RDI;
				else if (mleft != 2'h0)
					state <= S_RDM;
				else
					state <= S_EXEC;
			end
			S_RDM: begin
				o_rd <= 1'b1;
				o_io <= io;
				o_addr <= ea + {15'h0000, moff};
				state <= S_CAPM;
			end
			S_CAPM: begin
				mdat <= {i_din, mdat[15:8]};
				moff <= 1'b1;
				mleft <= mleft - 2'h1;
				state <= (mleft == 2'h1) ? S_EXEC : S_RDM;
			end
			S_EXEC: begin
				state <= S_PAD;
				if (k_ldrr) begin
					if (opc[5:3] == 3'h6) begin
						o_wr <= 1'b1;
						o_addr <= ea;
						o_dout <= src8;
					end else
						rf[opc[5:3]] <= src8;
				end else if (k_ldn) begin
					if (opc[5:3] == 3'h6) begin
						o_wr <= 1'b1;
						o_addr <= ea;
						o_dout <= n8;
					end else
						rf[opc[5:3]] <= n8;
				end else if (k_alu) begin
					if (opc[5:3] != 3'h7)
						rf[7] <= alu_res;
					rf[6] <= {alu_f[5], alu_f[4], fl[5], alu_f[3], fl[3], alu_f[2], alu_f[1], alu_f[0]};
				end else if (k_add16) begin
					put_pair(2'h2, 1'b0, s17[15:0]);
					rf[6] <= {fl[7:5], s13[12], fl[3:2], 1'b0, s17[16]};
				end else if (k_rot) begin
					rf[7] <= rot_res;
					rf[6] <= {fl[7:5], 1'b0, fl[3:2], 1'b0, rot_c};
				end else if (k_jr) begin
					if (jr_take)
						pc <= pc + {{8{n8[7]}}, n8};
				end else if (k_jp) begin
					if (opc == `CPUIDE_OP_JP || cond_ok(opc[5:3]))
						pc <= imm;
				end else if (k_push) begin
					o_wr <= 1'b1;
					o_addr <= sp - 16'h0001;
					o_dout <= qq[15:8];
					wa1 <= sp - 16'h0002;
					wd1 <= qq[7:0];
					sp <= sp - 16'h0002;
					state <= S_WR2;
				end else if (k_pop) begin
					put_pair(opc[5:4], 1'b1, mdat);
					sp <= sp + 16'h0002;
				end else if (k_st16 || k_edst) begin
					o_wr <= 1'b1;
					o_addr <= imm;
					o_dout <= k_st16 ? hlx[7:0] : pp[7:0];
					wa1 <= imm + 16'h0001;
					wd1 <= k_st16 ? hlx[15:8] : pp[15:8];
					state <= S_WR2;
				end else if (k_ina) begin
					rf[7] <= byte8;
				end else if (k_edin) begin
					if (opc[5:3] != 3'h6)
						rf[opc[5:3]] <= byte8;
					rf[6] <= {byte8[7], (byte8 == 8'h00), fl[5], 1'b0, fl[3], ~^byte8, 1'b0, fl[0]};
				end else if (k_jphl) begin
					pc <= hlx;
				end else if (k_ldsp) begin
					sp <= hlx;
				end else if (k_cps) begin
					rf[0] <= bcm[15:8];
					rf[1] <= bcm[7:0];
					{rf[4], rf[5]} <= opc[3] ? hl - 16'h0001 : hl + 16'h0001;
					rf[6] <= {alu_f[5], alu_f[4], fl[5], alu_f[3], fl[3], (bcm != 16'h0000), 1'b1, fl[0]};
					// Repeat by rewinding over the two opcode bytes
					if (opc[4] && bcm != 16'h0000 && !alu_f[4]) begin
						pc <= pc - 16'h0002;
						target <= `CPUIDE_T_CPS_RPT;
					end
				end
			end
			S_WR2: begin
				o_wr <= 1'b1;
				o_addr <= wa1;
				o_dout <= wd1;
				state <= S_PAD;
			end
			S_PAD: begin
				if (tcnt + 5'h01 >= target)
					state <= S_FETCH;
			end
			default: state <= S_FETCH;
			endcase
		end
	end
endmodule
